/* File: core/ps2h_filt.sv */
`timescale 1ns/1ps
module ps2h_filt import ps2h_pkg::*; (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] pins,
  ps2h_if.filt            bus
);
  logic [1:0] flt;
  logic       prev_q;

  // ----------------------------------------
  // Two-stage sync, then a level must hold FILT_CYC cycles
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_wire
    logic       s1_q;
    logic       s2_q;
    logic       flt_q;
    logic [3:0] cnt_q;
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
      end else begin
        s1_q <= pins[i];
        s2_q <= s1_q;
      end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        flt_q <= 1'b1;
        cnt_q <= '0;
      end else if (s2_q == flt_q) begin
        cnt_q <= '0;
      end else if (cnt_q == 4'(FILT_CYC - 1)) begin
        flt_q <= s2_q;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
    assign flt[i] = flt_q;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= flt[0];
    end
  end

  assign bus.clk_lvl  = flt[0];
  assign bus.dat_lvl  = flt[1];
  assign bus.clk_fall = prev_q & ~flt[0];
endmodule

/* File: core/ps2h_if.sv */
`timescale 1ns/1ps
interface ps2h_if;
  logic clk_lvl;
  logic dat_lvl;
  logic clk_fall;
  logic clk_drv;
  logic dat_drv;
  logic tx_busy;

  modport filt (output clk_lvl, dat_lvl, clk_fall);
  modport tx   (input clk_lvl, dat_lvl, clk_fall, output clk_drv, dat_drv, tx_busy);
  modport core (input clk_lvl, dat_lvl, clk_fall, clk_drv, dat_drv, tx_busy);
endinterface

/* File: core/ps2h_pkg.sv */
package ps2h_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int T_INHIBIT_US   = 100;
  localparam int INHIBIT_CYC    = T_INHIBIT_US * CLK_MHZ;
  localparam int T_FRAME_GAP_US = 200;
  localparam int FRAME_GAP_CYC  = T_FRAME_GAP_US * CLK_MHZ;
  localparam int T_RESP_MS      = 20;
  localparam int RESP_CYC       = T_RESP_MS * 1000 * CLK_MHZ;
  localparam int FILT_CYC       = 8;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_LAST = 10;
  localparam int TX_LAST    = 9;
  localparam int PKT_LAST   = 2;

  // ----------------------------------------
  // Byte codes
  // ----------------------------------------
  localparam logic [7:0] CODE_EXT    = 8'he0;
  localparam logic [7:0] CODE_BRK    = 8'hf0;
  localparam logic [7:0] CODE_ACK    = 8'hfa;
  localparam logic [7:0] CODE_ECHO   = 8'hee;
  localparam logic [7:0] CODE_LSHIFT = 8'h12;
  localparam logic [7:0] CODE_RSHIFT = 8'h59;
  localparam logic [7:0] BYTE_RST    = 8'h00;

  // ----------------------------------------
  // Mouse status byte and indicator byte fields
  // ----------------------------------------
  localparam int ST_LEFT    = 0;
  localparam int ST_RIGHT   = 1;
  localparam int ST_SYNC    = 3;
  localparam int ST_X_SIGN  = 4;
  localparam int ST_Y_SIGN  = 5;
  localparam int ST_X_OVF   = 6;
  localparam int ST_Y_OVF   = 7;
  localparam int LED_SCROLL = 0;
  localparam int LED_NUM    = 1;
  localparam int LED_CAPS   = 2;

  function automatic logic odd_par(input logic [7:0] d);
    return ~^d;
  endfunction

endpackage

/* File: core/ps2h_top.sv */
`timescale 1ns/1ps
module ps2h_top import ps2h_pkg::*; #(
  parameter int INHIBIT_CYC_P   = INHIBIT_CYC,
  parameter int FRAME_GAP_CYC_P = FRAME_GAP_CYC,
  parameter int RESP_CYC_P      = RESP_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       ps2_clk_pin,
  output logic            ps2_clk_val,
  output logic            ps2_clk_oe_n,
  input  wire logic       ps2_dat_pin,
  output logic            ps2_dat_val,
  output logic            ps2_dat_oe_n,
  input  wire logic       mouse_mode,
  input  wire logic       host_inhibit,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic [7:0] cmd_arg,
  input  wire logic       cmd_has_arg,
  output logic            cmd_ready,
  output logic            cmd_done,
  output logic            cmd_ok,
  output logic [7:0]      cmd_resp,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_frame_err,
  output logic            key_valid,
  output logic [7:0]      key_code,
  output logic            key_release,
  output logic            key_extended,
  output logic            shift_held,
  output logic            mouse_valid,
  output logic            mouse_btn_l,
  output logic            mouse_btn_r,
  output logic            x_sign_bit,
  output logic            y_sign_bit,
  output logic            x_overflow_bit,
  output logic            y_overflow_bit,
  output logic [8:0]      mouse_dx,
  output logic [8:0]      mouse_dy
);
  localparam int GW = $clog2(FRAME_GAP_CYC_P + 1);
  localparam int RW = $clog2(RESP_CYC_P + 1);

  typedef enum logic [4:0] {
    SQ_IDLE  = 5'b00001,
    SQ_SEND1 = 5'b00010,
    SQ_WACK1 = 5'b00100,
    SQ_SEND2 = 5'b01000,
    SQ_WACK2 = 5'b10000
  } ps2h_sq_e;

  ps2h_if bus ();

  ps2h_sq_e      sq_q;
  logic [7:0]    c_byte_q;
  logic [7:0]    c_arg_q;
  logic          c_has_q;
  logic [RW-1:0] rt_q;
  logic          tx_start;
  logic          tx_abort;
  logic          tx_done;
  logic          tx_err;
  logic          inh_q;
  logic [10:1]   sh_q;
  logic [3:0]    bc_q;
  logic [GW-1:0] gap_q;
  logic [10:0]   frame;
  logic          frame_end;
  logic          rx_valid_q;
  logic [7:0]    rx_data_q;
  logic          rx_err_q;
  logic          consumed;
  logic          kbd_byte;
  logic          ms_byte;
  logic          ext_q;
  logic          brk_q;
  logic [1:0]    shift_q;
  logic          key_valid_q;
  logic [7:0]    key_code_q;
  logic          key_rel_q;
  logic          key_ext_q;
  logic [1:0]    pidx_q;
  logic [7:0]    st_byte_q;
  logic [7:0]    x_byte_q;
  logic          m_valid_q;
  logic [7:0]    m_st_q;
  logic [8:0]    m_dx_q;
  logic [8:0]    m_dy_q;
  logic          done_q;
  logic          ok_q;
  logic [7:0]    resp_q;

  // ----------------------------------------
  // Wire conditioning and host transmitter
  // ----------------------------------------
  ps2h_filt i_ps2h_filt (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pins     ({ps2_dat_pin, ps2_clk_pin}),
    .bus      (bus)
  );

  ps2h_tx #(.INH_CYC(INHIBIT_CYC_P)) i_ps2h_tx (
    .core_clk (core_clk),
    .rstn     (rstn),
    .start    (tx_start),
    .abort    (tx_abort),
    .data     ((sq_q == SQ_SEND2) ? c_arg_q : c_byte_q),
    .done     (tx_done),
    .ack_err  (tx_err),
    .bus      (bus)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      inh_q <= 1'b0;
    end else begin
      inh_q <= host_inhibit && (sq_q == SQ_IDLE) && !bus.tx_busy;
    end
  end

  assign ps2_clk_val  = 1'b0;
  assign ps2_dat_val  = 1'b0;
  assign ps2_clk_oe_n = ~(bus.clk_drv | inh_q);
  assign ps2_dat_oe_n = ~bus.dat_drv;

  // ----------------------------------------
  // Frame receiver
  // ----------------------------------------
  assign frame     = {bus.dat_lvl, sh_q};
  assign frame_end = bus.clk_fall && !bus.tx_busy && !inh_q && (bc_q == 4'(FRAME_LAST));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sh_q  <= '0;
      bc_q  <= '0;
      gap_q <= '0;
    end else if (bus.tx_busy || inh_q) begin
      bc_q  <= '0;
      gap_q <= '0;
    end else if (bus.clk_fall) begin
      sh_q  <= frame[10:1];
      bc_q  <= frame_end ? 4'h0 : bc_q + 4'h1;
      gap_q <= '0;
    end else if (bc_q != 4'h0) begin
      if (gap_q == GW'(FRAME_GAP_CYC_P - 1)) begin
        bc_q  <= '0;
        gap_q <= '0;
      end else begin
        gap_q <= gap_q + GW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_valid_q <= 1'b0;
      rx_err_q   <= 1'b0;
      rx_data_q  <= BYTE_RST;
    end else begin
      rx_valid_q <= 1'b0;
      rx_err_q   <= 1'b0;
      if (frame_end) begin
        if (!frame[0] && frame[10] && frame[9] == odd_par(frame[8:1])) begin
          rx_valid_q <= 1'b1;
          rx_data_q  <= frame[8:1];
        end else begin
          rx_err_q <= 1'b1;
        end
      end
    end
  end

  assign consumed = rx_valid_q && (sq_q == SQ_WACK1 || sq_q == SQ_WACK2);
  assign kbd_byte = rx_valid_q && !consumed && !mouse_mode;
  assign ms_byte  = rx_valid_q && !consumed && mouse_mode;

  // ----------------------------------------
  // Keyboard decoder
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_q <= 1'b0;
      brk_q <= 1'b0;
    end else if (rx_err_q) begin
      ext_q <= 1'b0;
      brk_q <= 1'b0;
    end else if (kbd_byte) begin
      if (rx_data_q == CODE_EXT) begin
        ext_q <= 1'b1;
      end else if (rx_data_q == CODE_BRK) begin
        brk_q <= 1'b1;
      end else begin
        ext_q <= 1'b0;
        brk_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_valid_q <= 1'b0;
      key_code_q  <= BYTE_RST;
      key_rel_q   <= 1'b0;
      key_ext_q   <= 1'b0;
    end else begin
      key_valid_q <= 1'b0;
      if (kbd_byte && rx_data_q != CODE_EXT && rx_data_q != CODE_BRK) begin
        key_valid_q <= 1'b1;
        key_code_q  <= rx_data_q;
        key_rel_q   <= brk_q;
        key_ext_q   <= ext_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 2'b00;
    end else if (kbd_byte && !ext_q) begin
      if (rx_data_q == CODE_LSHIFT) begin
        shift_q[0] <= ~brk_q;
      end else if (rx_data_q == CODE_RSHIFT) begin
        shift_q[1] <= ~brk_q;
      end
    end
  end

  // ----------------------------------------
  // Mouse report assembly
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pidx_q    <= '0;
      st_byte_q <= BYTE_RST;
      x_byte_q  <= BYTE_RST;
    end else if (rx_err_q || !mouse_mode) begin
      pidx_q <= '0;
    end else if (ms_byte) begin
      if (pidx_q == 2'(0)) begin
        st_byte_q <= rx_data_q;
        if (rx_data_q[ST_SYNC]) begin
          pidx_q <= 2'd1;
        end
      end else if (pidx_q == 2'(PKT_LAST)) begin
        pidx_q <= '0;
      end else begin
        x_byte_q <= rx_data_q;
        pidx_q   <= pidx_q + 2'd1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      m_valid_q <= 1'b0;
      m_st_q    <= BYTE_RST;
      m_dx_q    <= '0;
      m_dy_q    <= '0;
    end else begin
      m_valid_q <= 1'b0;
      if (ms_byte && pidx_q == 2'(PKT_LAST) && !rx_err_q) begin
        m_valid_q <= 1'b1;
        m_st_q    <= st_byte_q;
        m_dx_q    <= {st_byte_q[ST_X_SIGN], x_byte_q};
        m_dy_q    <= {st_byte_q[ST_Y_SIGN], rx_data_q};
      end
    end
  end

  // ----------------------------------------
  // Command sequencer: command, wait answer, optional argument
  // ----------------------------------------
  assign tx_start = (sq_q == SQ_SEND1 || sq_q == SQ_SEND2) && !bus.tx_busy;
  assign tx_abort = (sq_q != SQ_IDLE) && (rt_q == RW'(RESP_CYC_P - 1));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rt_q <= '0;
    end else if (sq_q == SQ_IDLE || tx_start || tx_abort) begin
      rt_q <= '0;
    end else begin
      rt_q <= rt_q + RW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sq_q     <= SQ_IDLE;
      c_byte_q <= BYTE_RST;
      c_arg_q  <= BYTE_RST;
      c_has_q  <= 1'b0;
    end else if (tx_abort || (tx_done && tx_err)) begin
      sq_q <= SQ_IDLE;
    end else begin
      unique case (sq_q)
        SQ_IDLE: begin
          if (cmd_valid && !bus.tx_busy) begin
            c_byte_q <= cmd_byte;
            c_arg_q  <= cmd_arg;
            c_has_q  <= cmd_has_arg;
            sq_q     <= SQ_SEND1;
          end
        end
        SQ_SEND1: if (tx_start) sq_q <= SQ_WACK1;
        SQ_WACK1: begin
          if (rx_valid_q) begin
            sq_q <= (rx_data_q == CODE_ACK && c_has_q) ? SQ_SEND2 : SQ_IDLE;
          end
        end
        SQ_SEND2: if (tx_start) sq_q <= SQ_WACK2;
        SQ_WACK2: if (rx_valid_q) sq_q <= SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      ok_q   <= 1'b0;
      resp_q <= BYTE_RST;
    end else begin
      done_q <= 1'b0;
      if (tx_abort || (tx_done && tx_err && sq_q != SQ_IDLE)) begin
        done_q <= 1'b1;
        ok_q   <= 1'b0;
      end else if (consumed && !(sq_q == SQ_WACK1 && rx_data_q == CODE_ACK && c_has_q)) begin
        done_q <= 1'b1;
        ok_q   <= (rx_data_q == CODE_ACK) || (rx_data_q == CODE_ECHO);
        resp_q <= rx_data_q;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_ready      = (sq_q == SQ_IDLE) && !bus.tx_busy;
  assign cmd_done       = done_q;
  assign cmd_ok         = ok_q;
  assign cmd_resp       = resp_q;
  assign rx_valid       = rx_valid_q;
  assign rx_data        = rx_data_q;
  assign rx_frame_err   = rx_err_q;
  assign key_valid      = key_valid_q;
  assign key_code       = key_code_q;
  assign key_release    = key_rel_q;
  assign key_extended   = key_ext_q;
  assign shift_held     = |shift_q;
  assign mouse_valid    = m_valid_q;
  assign mouse_btn_l    = m_st_q[ST_LEFT];
  assign mouse_btn_r    = m_st_q[ST_RIGHT];
  assign x_sign_bit     = m_st_q[ST_X_SIGN];
  assign y_sign_bit     = m_st_q[ST_Y_SIGN];
  assign x_overflow_bit = m_st_q[ST_X_OVF];
  assign y_overflow_bit = m_st_q[ST_Y_OVF];
  assign mouse_dx       = m_dx_q;
  assign mouse_dy       = m_dy_q;
endmodule

/* File: core/ps2h_tx.sv */
`timescale 1ns/1ps
module ps2h_tx import ps2h_pkg::*; #(
  parameter int INH_CYC = INHIBIT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [7:0] data,
  output logic            done,
  output logic            ack_err,
  ps2h_if.tx              bus
);
  localparam int CW = $clog2(INH_CYC + 1);

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_INH  = 5'b00010,
    TX_BITS = 5'b00100,
    TX_ACK  = 5'b01000,
    TX_END  = 5'b10000
  } ps2h_tx_e;

  ps2h_tx_e      st_q;
  logic [CW-1:0] cnt_q;
  logic [9:0]    sh_q;
  logic [3:0]    idx_q;
  logic          clk_drv_q;
  logic          dat_drv_q;
  logic          done_q;
  logic          err_q;
  logic          inh_end;

  assign inh_end     = (st_q == TX_INH) && (cnt_q == CW'(INH_CYC - 1));
  assign bus.tx_busy = (st_q != TX_IDLE);
  assign bus.clk_drv = clk_drv_q;
  assign bus.dat_drv = dat_drv_q;
  assign done        = done_q;
  assign ack_err     = err_q;

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= TX_IDLE;
    end else if (abort) begin
      st_q <= TX_IDLE;
    end else begin
      unique case (st_q)
        TX_IDLE: if (start) st_q <= TX_INH;
        TX_INH:  if (inh_end) st_q <= TX_BITS;
        TX_BITS: if (bus.clk_fall && idx_q == 4'(TX_LAST)) st_q <= TX_ACK;
        TX_ACK:  if (bus.clk_fall) st_q <= TX_END;
        TX_END:  if (bus.clk_lvl && bus.dat_lvl) st_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sh_q  <= '0;
      cnt_q <= '0;
      idx_q <= '0;
    end else if (st_q == TX_IDLE && start) begin
      sh_q  <= {1'b1, odd_par(data), data};
      cnt_q <= '0;
      idx_q <= '0;
    end else if (st_q == TX_INH) begin
      cnt_q <= cnt_q + CW'(1);
    end else if (st_q == TX_BITS && bus.clk_fall) begin
      sh_q  <= {1'b1, sh_q[9:1]};
      idx_q <= idx_q + 4'h1;
    end
  end

  // ----------------------------------------
  // Wire drivers: pull low only
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_drv_q <= 1'b0;
      dat_drv_q <= 1'b0;
    end else if (abort) begin
      clk_drv_q <= 1'b0;
      dat_drv_q <= 1'b0;
    end else if (st_q == TX_IDLE && start) begin
      clk_drv_q <= 1'b1;
    end else if (inh_end) begin
      clk_drv_q <= 1'b0;
      dat_drv_q <= 1'b1;
    end else if (st_q == TX_BITS && bus.clk_fall) begin
      dat_drv_q <= ~sh_q[0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      done_q <= (st_q == TX_END) && bus.clk_lvl && bus.dat_lvl && !abort;
      if (st_q == TX_ACK && bus.clk_fall) begin
        err_q <= bus.dat_lvl;
      end
    end
  end
endmodule

/* File: dv/ps2h_dev.sv */
`timescale 1ns/1ps
module ps2h_dev (
  input  wire logic clk_w,
  input  wire logic dat_w,
  output logic      clk_pull,
  output logic      dat_pull
);
  logic [7:0] got [$];
  logic [9:0] r;
  logic [7:0] last_code;
  bit         busy;

  initial begin
    clk_pull = 1'b0;
    dat_pull = 1'b0;
    last_code = 8'h00;
  end

  task automatic send(input logic [7:0] b, input logic [1:0] bad);
    logic [10:0] f;
    f = {~bad[1], ~^b ^ bad[0], b, 1'b0};
    if (b != 8'hfa && b != 8'hee) last_code = b;
    wait (clk_w && dat_w && !busy);
    busy = 1'b1;
    #1003;  // Keep wire edges off the host's sampling edge
    for (int i = 0; i < 11; i++) begin
      dat_pull = ~f[i];
      #40 clk_pull = 1'b1;
      #80 clk_pull = 1'b0;
      #40;
    end
    dat_pull = 1'b0;
    busy = 1'b0;
  endtask

  // Host frame: sample late in the high phase, then acknowledge and answer
  always begin
    wait (!dat_w && clk_w && !busy);
    busy = 1'b1;
    #243;  // Let the host filter see the released clock first
    for (int i = 0; i < 10; i++) begin
      clk_pull = 1'b1;
      #80 clk_pull = 1'b0;
      #75 r[i] = dat_w;
      #5;
    end
    dat_pull = 1'b1;
    #20 clk_pull = 1'b1;
    #80 clk_pull = 1'b0;
    #80 dat_pull = 1'b0;
    got.push_back(r[7:0]);
    busy = 1'b0;
    #2000;
    if (r[9] && r[8] == ~^r[7:0])
      send(r[7:0] == 8'hee ? 8'hee : r[7:0] == 8'hfe ? last_code : 8'hfa,
           2'b00);
  end
endmodule

/* File: dv/ps2h_top_sva.sv */
`timescale 1ns/1ps
module ps2h_chk (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       ps2_clk_val,
  input wire logic       ps2_clk_oe_n,
  input wire logic       ps2_dat_val,
  input wire logic       ps2_dat_oe_n,
  input wire logic       mouse_mode,
  input wire logic       host_inhibit,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       cmd_done,
  input wire logic       cmd_ok,
  input wire logic       rx_valid,
  input wire logic       rx_frame_err,
  input wire logic       key_valid,
  input wire logic       mouse_valid,
  input wire logic       x_sign_bit,
  input wire logic       y_sign_bit,
  input wire logic [8:0] mouse_dx,
  input wire logic [8:0] mouse_dy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_take; cmd_valid && cmd_ready; endsequence
  sequence s_pull; !ps2_clk_oe_n [*8]; endsequence
  property p_start; s_take |-> ##[1:4] s_pull; endproperty
  a_start: assert property (p_start) else $error("no clock pull");
  property p_busy; s_take |=> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_od; !ps2_clk_val && !ps2_dat_val; endproperty
  a_od: assert property (p_od) else $error("wire driven high");
  property p_idle;
    cmd_ready && !host_inhibit && !$past(host_inhibit) |-> ps2_clk_oe_n && ps2_dat_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("wire pulled at idle");
  property p_inh; host_inhibit && cmd_ready && !cmd_valid |=> !ps2_clk_oe_n; endproperty
  a_inh: assert property (p_inh) else $error("inhibit missing");
  property p_excl; !(rx_valid && rx_frame_err); endproperty
  a_excl: assert property (p_excl) else $error("byte and error");
  property p_key; key_valid |-> $past(rx_valid) && !mouse_mode; endproperty
  a_key: assert property (p_key) else $error("stray key");
  property p_mou; mouse_valid |-> $past(rx_valid) && $past(mouse_mode); endproperty
  a_mou: assert property (p_mou) else $error("stray report");
  property p_sign;
    mouse_valid |-> mouse_dx[8] == x_sign_bit && mouse_dy[8] == y_sign_bit;
  endproperty
  a_sign: assert property (p_sign) else $error("sign differs");
  property p_done; cmd_done && cmd_ok |-> $past(rx_valid); endproperty
  a_done: assert property (p_done) else $error("done without answer");
endmodule

/* File: dv/ps2h_top_tb_top.sv */
`timescale 1ns/1ps
module ps2h_top_tb_top import ps2h_pkg::*;;
  logic       core_clk = 1'b0, rstn = 1'b0, mouse_mode = 1'b0, host_inhibit = 1'b0;
  logic       cmd_valid = 1'b0, cmd_has_arg = 1'b0, dev_cp, dev_dp, d_ok;
  logic [7:0] cmd_byte = 8'h00, cmd_arg = 8'h00, cmd_resp, rx_data, key_code, d_resp;
  logic       ps2_clk_val, ps2_clk_oe_n, ps2_dat_val, ps2_dat_oe_n, cmd_ready, cmd_done, cmd_ok;
  logic       rx_valid, rx_frame_err, key_valid, key_release, key_extended, shift_held;
  logic       mouse_valid, mouse_btn_l, mouse_btn_r, x_sign_bit, y_sign_bit;
  logic       x_overflow_bit, y_overflow_bit;
  logic [8:0] mouse_dx, mouse_dy;
  logic [9:0] k_last;
  int         n_fail = 0, n_tests = 0, n_key = 0, n_rx = 0, n_err = 0, n_mou = 0, n_done = 0;
  wire        clk_w = !dev_cp && (ps2_clk_oe_n || ps2_clk_val);
  wire        dat_w = !dev_dp && (ps2_dat_oe_n || ps2_dat_val);

  ps2h_top #(.INHIBIT_CYC_P(50), .FRAME_GAP_CYC_P(400), .RESP_CYC_P(5000)) i_ps2h_top (
    .core_clk, .rstn, .ps2_clk_pin(clk_w), .ps2_clk_val, .ps2_clk_oe_n, .ps2_dat_pin(dat_w),
    .ps2_dat_val, .ps2_dat_oe_n, .mouse_mode, .host_inhibit, .cmd_valid, .cmd_byte, .cmd_arg,
    .cmd_has_arg, .cmd_ready, .cmd_done, .cmd_ok, .cmd_resp, .rx_valid, .rx_data,
    .rx_frame_err, .key_valid, .key_code, .key_release, .key_extended, .shift_held,
    .mouse_valid, .mouse_btn_l, .mouse_btn_r, .x_sign_bit, .y_sign_bit, .x_overflow_bit,
    .y_overflow_bit, .mouse_dx, .mouse_dy);
  ps2h_dev i_ps2h_dev (.clk_w, .dat_w, .clk_pull(dev_cp), .dat_pull(dev_dp));

  always #5 core_clk = ~core_clk;

  always @(negedge core_clk) begin
    if (key_valid === 1'b1) begin
      n_key++;
      k_last = {key_release, key_extended, key_code};
    end
    if (rx_valid === 1'b1) n_rx++;
    if (rx_frame_err === 1'b1) n_err++;
    if (mouse_valid === 1'b1) n_mou++;
    if (cmd_done === 1'b1) begin
      n_done++;
      d_ok = cmd_ok;
      d_resp = cmd_resp;
    end
  end

  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic kb(input logic [7:0] b, input logic [1:0] bad = 2'b00);
    i_ps2h_dev.send(b, bad);
    repeat (30) @(negedge core_clk);
  endtask

  task automatic t_kbd();
    int n;
    n = n_key;
    kb(8'h1c);
    kb(8'h1c);
    chk(10'(n_key - n), 10'h002);
    chk(k_last, 10'h01c);
    kb(CODE_BRK);
    kb(8'h1c);
    chk(k_last, 10'h21c);
    kb(CODE_EXT);
    kb(CODE_BRK);
    kb(8'h74);
    chk(k_last, 10'h374);
    chk(10'(n_key - n), 10'h004);
    kb(CODE_LSHIFT);
    chk(10'(shift_held), 10'h001);
    kb(CODE_BRK);
    kb(CODE_LSHIFT);
    chk(10'(shift_held), 10'h000);
  endtask

  task automatic t_err();
    int e, r;
    e = n_err;
    r = n_rx;
    chk(10'(rx_data), 10'(CODE_LSHIFT));
    kb(8'h55, 2'b01);
    kb(8'h55, 2'b10);
    chk(10'(n_err - e), 10'h002);
    chk(10'(n_rx - r), 10'h000);
    chk(10'(rx_data), 10'(CODE_LSHIFT));
  endtask

  task automatic t_mouse();
    int n;
    n = n_mou;
    @(posedge core_clk) mouse_mode <= 1'b1;
    kb(8'hf9);
    kb(8'h80);
    kb(8'h01);
    chk(10'(n_mou - n), 10'h001);
    chk(10'(mouse_dx), 10'h180);
    chk(10'(mouse_dy), 10'h101);
    chk({y_overflow_bit, x_overflow_bit, y_sign_bit, x_sign_bit, mouse_btn_r, mouse_btn_l},
        10'h03d);
    kb(8'h0a);
    kb(8'h05);
    kb(8'h03);
    chk(10'(n_mou - n), 10'h002);
    chk(10'(mouse_dx), 10'h005);
    chk({y_overflow_bit, x_overflow_bit, y_sign_bit, x_sign_bit, mouse_btn_r, mouse_btn_l},
        10'h002);
    @(posedge core_clk) mouse_mode <= 1'b0;
  endtask

  task automatic one_cmd(input logic [7:0] b, a, input logic ha, input logic [7:0] e);
    int n;
    n = n_done;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    cmd_arg <= a;
    cmd_has_arg <= ha;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    repeat (8000) begin
      @(negedge core_clk);
      if (n_done != n) break;
    end
    chk(10'(n_done - n), 10'h001);
    chk(10'(d_ok), 10'(e == CODE_ACK || e == CODE_ECHO));
    chk(10'(d_resp), 10'(e));
    chk(10'(i_ps2h_dev.got[$ - ha]), 10'(b));
    if (ha) chk(10'(i_ps2h_dev.got[$]), 10'(a));
  endtask

  task automatic t_cmd();
    one_cmd(CODE_ECHO, 8'h00, 1'b0, CODE_ECHO);
    one_cmd(8'hed, 8'h07, 1'b1, CODE_ACK);
    one_cmd(8'hf3, 8'h2a, 1'b1, CODE_ACK);
    one_cmd(8'hfe, 8'h00, 1'b0, 8'h03);
    one_cmd(8'hff, 8'h00, 1'b0, CODE_ACK);
  endtask

  task automatic t_inh();
    int n;
    n = n_key;
    @(posedge core_clk) host_inhibit <= 1'b1;
    repeat (5) @(negedge core_clk);
    fork
      kb(8'h2b);
      begin
        repeat (300) @(negedge core_clk);
        chk(10'(ps2_clk_oe_n), 10'h000);
        chk(10'(n_key - n), 10'h000);
        @(posedge core_clk) host_inhibit <= 1'b0;
      end
    join
    chk(k_last, 10'h02b);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (20) @(negedge core_clk);
    chk({ps2_clk_oe_n, ps2_dat_oe_n, cmd_ready}, 10'h007);
    t_kbd();
    t_err();
    t_mouse();
    t_cmd();
    t_inh();
    close_out();
  end

  initial begin
    #600000;
    n_fail++;
    close_out();
  end
endmodule

bind ps2h_top ps2h_chk i_ps2h_chk (
  .core_clk, .rstn, .ps2_clk_val, .ps2_clk_oe_n, .ps2_dat_val, .ps2_dat_oe_n, .mouse_mode,
  .host_inhibit, .cmd_valid, .cmd_ready, .cmd_done, .cmd_ok, .rx_valid, .rx_frame_err,
  .key_valid, .mouse_valid, .x_sign_bit, .y_sign_bit, .mouse_dx, .mouse_dy);
